// file: hdl/fetch_byte_fifo.sv
// Byte FIFO between the flash receiver and the code reader.
// Assumes one clock domain; push and pop follow valid and ready on each side.
`timescale 1ns/1ps
module fetch_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	// Fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] rd_ptr_ff;
	logic [PW:0] count_ff;
	logic push;
	logic pop;

	assign in_ready_out = (count_ff != (PW+1)'(DEPTH));
	assign out_valid_out = (count_ff != '0);
	assign out_data_out = mem[rd_ptr_ff];
	assign push = in_valid_in && in_ready_out && ce_in;
	assign pop = out_valid_out && out_ready_in && ce_in;

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule // fetch_byte_fifo

// file: hdl/spi_rom_fetch_and_straps.sv
// Serial flash code-fetch sequencer with boot signature check and strap latch.
// Assumes flash and strap pins are asynchronous; processor signals share clk_in.
`timescale 1ns/1ps
module spi_rom_fetch_and_straps
	import spi_rom_fetch_pkg::*;
(
	// Clock, reset and enable
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	// Configuration and power state
	input wire logic spi_disable_in,
	input wire logic suspend_in,
	// Processor code fetch
	input wire logic cpu_rd_in,
	input wire logic [16:0] cpu_addr_in,
	input wire logic cpu_stall_in,
	output logic cpu_ready_out,
	output logic [7:0] cpu_data_out,
	output logic ext_rom_en_out,
	output logic boot_done_out,
	// Serial flash pins
	output logic flash_cs_b_out,
	output logic flash_sck_out,
	output logic flash_mosi_out,
	input wire logic flash_miso_in,
	// Strap pins
	input wire logic [STRAP_COUNT-1:0] strap_pin_in,
	input wire logic [STRAP_COUNT-1:0] strap_func_in,
	output logic [STRAP_COUNT-1:0] strap_pin_out,
	output logic [STRAP_COUNT-1:0] strap_pin_oe_out,
	// Latched strap results
	output logic [PORT_COUNT-1:0] port_neg_line_off_out,
	output logic [PORT_COUNT-1:0] port_pos_line_off_out,
	output logic [PORT_COUNT-1:0] port_disable_out,
	output logic fast_flash_clk_out
);
	function automatic logic [7:0] sig_byte(input logic [1:0] idx);
		sig_byte = SIG_CHARS[8'(31 - 8 * idx) -: 8];
	endfunction

	fetch_state_t state_ff;
	boot_state_t boot_ff;
	logic miso_s1_ff;
	logic miso_s2_ff;
	logic [STRAP_COUNT-1:0] strap_s1_ff;
	logic [STRAP_COUNT-1:0] strap_s2_ff;
	logic [1:0] settle_ff;
	logic strap_latched_ff;
	logic [3:0] half_cnt_ff;
	logic [4:0] bit_cnt_ff;
	logic [31:0] tx_sh_ff;
	logic [7:0] rx_sh_ff;
	logic req_ff;
	logic [23:0] req_addr_ff;
	logic [23:0] last_addr_ff;
	logic [1:0] sig_idx_ff;
	logic sig_ok_ff;
	logic cs_b_ff;
	logic sck_ff;
	logic mosi_ff;
	logic push_ff;
	logic [7:0] push_data_ff;
	logic cpu_ready_ff;
	logic [7:0] cpu_data_ff;
	logic ext_en_ff;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [7:0] fifo_out_data;
	logic [3:0] half_len;
	logic shifting;
	logic tick;
	logic fall;
	logic last_bit;
	logic sequential;
	logic flash_idle;

	assign half_len = fast_flash_clk_out ? SCK_HALF_FAST : SCK_HALF_SLOW;
	assign shifting = (state_ff == S_TX) || (state_ff == S_DUMMY) || (state_ff == S_RX);
	assign tick = shifting && (half_cnt_ff == half_len - 4'h1);
	assign fall = tick && sck_ff;
	assign last_bit = (bit_cnt_ff == 5'h00);
	assign sequential = (req_addr_ff == last_addr_ff + 24'h000001);
	// Without a signature the flash is not ours to hold selected
	assign flash_idle = spi_disable_in || (boot_done_out && !ext_en_ff);

	// Pins come from outside the clock domain
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			miso_s1_ff <= 1'b0;
			miso_s2_ff <= 1'b0;
			strap_s1_ff <= '0;
			strap_s2_ff <= '0;
		end else if (ce_in) begin
			miso_s1_ff <= flash_miso_in;
			miso_s2_ff <= miso_s1_ff;
			strap_s1_ff <= strap_pin_in;
			strap_s2_ff <= strap_s1_ff;
		end
	end

	// Straps are caught once the synchroniser has filled after reset release
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			settle_ff <= 2'h0;
			strap_latched_ff <= 1'b0;
			port_neg_line_off_out <= '0;
			port_pos_line_off_out <= '0;
			port_disable_out <= '0;
			fast_flash_clk_out <= 1'b0;
		end else if (ce_in && !strap_latched_ff) begin
			settle_ff <= settle_ff + 2'h1;
			if (settle_ff == STRAP_SETTLE_M1) begin
				strap_latched_ff <= 1'b1;
				port_neg_line_off_out <= strap_s2_ff[STRAP_NEG_LSB +: PORT_COUNT];
				port_pos_line_off_out <= strap_s2_ff[STRAP_POS_LSB +: PORT_COUNT];
				port_disable_out <= strap_s2_ff[STRAP_NEG_LSB +: PORT_COUNT]
					& strap_s2_ff[STRAP_POS_LSB +: PORT_COUNT];
				fast_flash_clk_out <= strap_s2_ff[STRAP_SPEED_BIT];
			end
		end
	end

	// Strap pins float through reset and until their level has been caught
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			strap_pin_out <= '0;
			strap_pin_oe_out <= '0;
		end else if (ce_in && strap_latched_ff) begin
			strap_pin_out <= strap_func_in;
			strap_pin_oe_out <= '1;
			if (suspend_in) begin
				strap_pin_oe_out[STRAP_SPEED_BIT] <= !fast_flash_clk_out;
				strap_pin_out[STRAP_SPEED_BIT] <= 1'b0;
			end
		end
	end

	// Serial clock divider, idle low between frames (mode 0)
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			half_cnt_ff <= 4'h0;
			sck_ff <= 1'b0;
		end else if (ce_in) begin
			if (!shifting || flash_idle) begin
				half_cnt_ff <= 4'h0;
				sck_ff <= 1'b0;
			end else if (tick) begin
				half_cnt_ff <= 4'h0;
				sck_ff <= !sck_ff;
			end else begin
				half_cnt_ff <= half_cnt_ff + 4'h1;
			end
		end
	end

	// Transaction sequencer
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_ff <= S_IDLE;
			cs_b_ff <= 1'b1;
			mosi_ff <= 1'b0;
			bit_cnt_ff <= 5'h00;
			tx_sh_ff <= '0;
			rx_sh_ff <= '0;
			last_addr_ff <= '0;
			push_ff <= 1'b0;
			push_data_ff <= '0;
		end else if (ce_in) begin
			push_ff <= 1'b0;
			case (state_ff)
				S_IDLE: begin
					cs_b_ff <= 1'b1;
					if (req_ff && !flash_idle && fifo_in_ready && strap_latched_ff) begin
						cs_b_ff <= 1'b0;
						tx_sh_ff <= {FAST_READ_OPCODE, req_addr_ff};
						mosi_ff <= FAST_READ_OPCODE[7];
						bit_cnt_ff <= CMD_ADDR_BITS_M1;
						state_ff <= S_TX;
					end
				end
				S_TX: begin
					if (flash_idle) begin
						state_ff <= S_DESEL;
						cs_b_ff <= 1'b1;
					end else if (fall) begin
						tx_sh_ff <= {tx_sh_ff[30:0], 1'b0};
						mosi_ff <= tx_sh_ff[30];
						bit_cnt_ff <= bit_cnt_ff - 5'h01;
						if (last_bit) begin
							mosi_ff <= 1'b0;
							bit_cnt_ff <= BYTE_BITS_M1;
							state_ff <= S_DUMMY;
						end
					end
				end
				S_DUMMY: begin
					if (flash_idle) begin
						state_ff <= S_DESEL;
						cs_b_ff <= 1'b1;
					end else if (fall) begin
						bit_cnt_ff <= bit_cnt_ff - 5'h01;
						if (last_bit) begin
							bit_cnt_ff <= BYTE_BITS_M1;
							state_ff <= S_RX;
						end
					end
				end
				S_RX: begin
					if (flash_idle) begin
						state_ff <= S_DESEL;
						cs_b_ff <= 1'b1;
					end else if (fall) begin
						// Sampled at the end of the high phase; the synchroniser lags two cycles
						rx_sh_ff <= {rx_sh_ff[6:0], miso_s2_ff};
						bit_cnt_ff <= bit_cnt_ff - 5'h01;
						if (last_bit) begin
							push_ff <= 1'b1;
							push_data_ff <= {rx_sh_ff[6:0], miso_s2_ff};
							last_addr_ff <= req_addr_ff;
							state_ff <= S_WAIT;
						end
					end
				end
				S_WAIT: begin
					if (flash_idle) begin
						state_ff <= S_DESEL;
						cs_b_ff <= 1'b1;
					end else if (req_ff && !push_ff && sequential && fifo_in_ready) begin
						bit_cnt_ff <= BYTE_BITS_M1;
						state_ff <= S_RX;
					end else if (req_ff && !push_ff && !sequential) begin
						state_ff <= S_DESEL;
						cs_b_ff <= 1'b1;
					end
				end
				S_DESEL: begin
					cs_b_ff <= 1'b1;
					state_ff <= S_IDLE;
				end
				default: begin
					cs_b_ff <= 1'b1;
					state_ff <= S_IDLE;
				end
			endcase
		end
	end

	// Pending read request, from the boot check or the processor
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			req_ff <= 1'b0;
			req_addr_ff <= '0;
		end else if (ce_in) begin
			if (spi_disable_in) begin
				req_ff <= 1'b0;
			end else if (push_ff) begin
				req_ff <= 1'b0;
			end else if (!req_ff && boot_ff == B_REQ) begin
				req_ff <= 1'b1;
				req_addr_ff <= SIG_ADDR + {22'h000000, sig_idx_ff};
			end else if (!req_ff && cpu_rd_in && boot_done_out && ext_en_ff) begin
				req_ff <= 1'b1;
				req_addr_ff <= {7'h00, cpu_addr_in};
			end
		end
	end

	// Boot signature check
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			boot_ff <= B_STRAP;
			sig_idx_ff <= 2'h0;
			sig_ok_ff <= 1'b1;
			ext_en_ff <= 1'b0;
			boot_done_out <= 1'b0;
		end else if (ce_in) begin
			case (boot_ff)
				B_STRAP: begin
					if (strap_latched_ff) begin
						boot_ff <= spi_disable_in ? B_DONE : B_REQ;
						boot_done_out <= spi_disable_in;
					end
				end
				B_REQ: begin
					if (spi_disable_in) begin
						boot_ff <= B_DONE;
						boot_done_out <= 1'b1;
					end else if (!req_ff) begin
						boot_ff <= B_CHECK;
					end
				end
				B_CHECK: begin
					if (spi_disable_in) begin
						boot_ff <= B_DONE;
						boot_done_out <= 1'b1;
					end else if (fifo_out_valid) begin
						sig_idx_ff <= sig_idx_ff + 2'h1;
						sig_ok_ff <= sig_ok_ff && (fifo_out_data == sig_byte(sig_idx_ff));
						if (sig_idx_ff == SIG_LAST_IDX) begin
							ext_en_ff <= sig_ok_ff && (fifo_out_data == sig_byte(sig_idx_ff));
							boot_ff <= B_DONE;
							boot_done_out <= 1'b1;
						end else begin
							boot_ff <= B_REQ;
						end
					end
				end
				B_DONE: begin
					boot_done_out <= 1'b1;
				end
				default: begin
					boot_ff <= B_DONE;
				end
			endcase
		end
	end

	// Bytes are handed to the processor only after a valid signature
	assign fifo_out_ready = (boot_ff == B_CHECK) || (boot_done_out && !cpu_stall_in);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cpu_ready_ff <= 1'b0;
			cpu_data_ff <= '0;
		end else if (ce_in) begin
			cpu_ready_ff <= 1'b0;
			if (boot_done_out && !cpu_stall_in && fifo_out_valid) begin
				cpu_ready_ff <= ext_en_ff;
				cpu_data_ff <= fifo_out_data;
			end
		end
	end

	fetch_byte_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.ce_in(ce_in),
		.in_valid_in(push_ff),
		.in_ready_out(fifo_in_ready),
		.in_data_in(push_data_ff),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_out_ready),
		.out_data_out(fifo_out_data)
	);

	assign cpu_ready_out = cpu_ready_ff;
	assign cpu_data_out = cpu_data_ff;
	assign ext_rom_en_out = ext_en_ff;
	assign flash_cs_b_out = cs_b_ff;
	assign flash_sck_out = sck_ff;
	assign flash_mosi_out = mosi_ff;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	property p_strap_float;
		!strap_latched_ff |-> strap_pin_oe_out == '0;
	endproperty
	a_strap_float: assert property (p_strap_float) else $error("strap driven before latch");

	property p_port_disable;
		strap_latched_ff |-> port_disable_out == (port_neg_line_off_out & port_pos_line_off_out);
	endproperty
	a_port_disable: assert property (p_port_disable) else $error("port disable mismatch");

	property p_sck_half;
		$rose(flash_sck_out) |-> flash_sck_out[*2];
	endproperty
	a_sck_half: assert property (p_sck_half) else $error("serial clock high too short");

	property p_suspend_pin;
		ce_in && strap_latched_ff && suspend_in |=>
			strap_pin_oe_out[STRAP_SPEED_BIT] == !fast_flash_clk_out
			&& !strap_pin_out[STRAP_SPEED_BIT];
	endproperty
	a_suspend_pin: assert property (p_suspend_pin) else $error("speed pin wrong in suspend");

	property p_opcode_first;
		$fell(flash_cs_b_out) |-> state_ff == S_TX && tx_sh_ff[31:24] == FAST_READ_OPCODE
			&& !flash_sck_out && flash_mosi_out == FAST_READ_OPCODE[7];
	endproperty
	a_opcode_first: assert property (p_opcode_first) else $error("frame did not open with opcode");

	property p_seq_continue;
		ce_in && state_ff == S_WAIT && req_ff && !push_ff && sequential && fifo_in_ready
			&& !flash_idle |=> state_ff == S_RX && !flash_cs_b_out;
	endproperty
	a_seq_continue: assert property (p_seq_continue) else $error("sequential read not continued");

	property p_jump_ends;
		ce_in && state_ff == S_WAIT && req_ff && !push_ff && !sequential
			|=> flash_cs_b_out ##1 (!ce_in || state_ff == S_IDLE);
	endproperty
	a_jump_ends: assert property (p_jump_ends) else $error("jump did not end transfer");

	property p_disable_off;
		ce_in && spi_disable_in |=> flash_cs_b_out && !flash_sck_out;
	endproperty
	a_disable_off: assert property (p_disable_off) else $error("flash active while disabled");

	property p_ready_needs_sig;
		cpu_ready_out |-> boot_done_out && ext_rom_en_out;
	endproperty
	a_ready_needs_sig: assert property (p_ready_needs_sig) else $error("byte given without signature");

	property p_push_from_rx;
		$rose(push_ff) |-> $past(state_ff) == S_RX && state_ff == S_WAIT;
	endproperty
	a_push_from_rx: assert property (p_push_from_rx) else $error("byte pushed outside receive");
endmodule // spi_rom_fetch_and_straps

// file: hdl/spi_rom_fetch_pkg.sv
// Constants and types shared by the serial flash fetch controller and its byte FIFO.
// Assumes a 25 MHz core clock; strap and flash input pins are asynchronous to it.
// Operation
// - Strap pins drive normally, float during reset.
// - Latch strap levels at reset release, hold.
// - Port disabled only when both straps high.
// - Strap high disables that data line.
// - Speed strap 0 slow clock, 1 fast; both settings give a half period of 2 core cycles here.
// - Fast strap: speed pin floats in suspend.
// - Slow strap: speed pin driven low in suspend.
// - At power-up check signature at 0xFFFA.
// - Valid signature enables external code at zero.
// - No signature: flash never used for code.
// - Interface enabled after every reset.
// - Disable input turns the interface off.
// - Chip select low, opcode, 24-bit address.
// - One dummy byte before read data.
// - First byte sampled in next eight clocks.
// - Full byte gives ready and data.
// - Sequential address keeps select, reads another byte.
// - Non-sequential address raises chip select.
package spi_rom_fetch_pkg;
	localparam int CLK_FREQ_MHZ = 25;
	localparam int SCK_SLOW_MHZ = 30;
	localparam int SCK_FAST_MHZ = 60;
	// A half period is a least time, so it rounds up; two cycles cover the input synchroniser
	localparam int SCK_HALF_MIN = 2;
	localparam int SCK_HALF_SLOW_RAW = (CLK_FREQ_MHZ + 2 * SCK_SLOW_MHZ - 1) / (2 * SCK_SLOW_MHZ);
	localparam int SCK_HALF_FAST_RAW = (CLK_FREQ_MHZ + 2 * SCK_FAST_MHZ - 1) / (2 * SCK_FAST_MHZ);
	localparam logic [3:0] SCK_HALF_SLOW =
		4'((SCK_HALF_SLOW_RAW > SCK_HALF_MIN) ? SCK_HALF_SLOW_RAW : SCK_HALF_MIN);
	localparam logic [3:0] SCK_HALF_FAST =
		4'((SCK_HALF_FAST_RAW > SCK_HALF_MIN) ? SCK_HALF_FAST_RAW : SCK_HALF_MIN);
	localparam logic [7:0] FAST_READ_OPCODE = 8'h0B;
	localparam logic [4:0] CMD_ADDR_BITS_M1 = 5'h1F;
	localparam logic [4:0] BYTE_BITS_M1 = 5'h07;
	localparam logic [23:0] SIG_ADDR = 24'h00FFFA;
	localparam logic [31:0] SIG_CHARS = 32'h32444655;
	localparam logic [1:0] SIG_LAST_IDX = 2'h3;
	localparam int STRAP_COUNT = 9;
	localparam int PORT_COUNT = 4;
	localparam int STRAP_NEG_LSB = 0;
	localparam int STRAP_POS_LSB = 4;
	localparam int STRAP_SPEED_BIT = 8;
	localparam logic [1:0] STRAP_SETTLE_M1 = 2'h2;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_TX = 3'b001,
		S_DUMMY = 3'b010,
		S_RX = 3'b011,
		S_WAIT = 3'b100,
		S_DESEL = 3'b101
	} fetch_state_t;

	typedef enum logic [1:0] {
		B_STRAP = 2'b00,
		B_REQ = 2'b01,
		B_CHECK = 2'b10,
		B_DONE = 2'b11
	} boot_state_t;
endpackage

// file: test/flash_rom_model.sv
// Behavioural serial flash answering fast reads in clock mode 0.
// Assumes select and clock come straight from the controller pins.
`timescale 1ns/1ps
module flash_rom_model (
	// Serial pins
	input wire logic cs_b_in,
	input wire logic sck_in,
	input wire logic mosi_in,
	output logic miso_out,
	// Content choice and observation
	input wire logic sig_ok_in,
	output logic [7:0] opcode_out,
	output logic [23:0] addr_out,
	output int frames_out
);
	int bit_cnt;
	int idx;
	logic [31:0] cmd;
	logic [7:0] cur;

	function automatic logic [7:0] rom_byte(input logic [23:0] a, input logic ok);
		logic [31:0] sig;
		sig = 32'h32444655;
		if (ok && a >= 24'h00FFFA && a <= 24'h00FFFD)
			return sig[31 - 8 * int'(a - 24'h00FFFA) -: 8];
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction

	initial begin
		miso_out = 1'b0;
		bit_cnt = 0;
		frames_out = 0;
		cmd = 32'h00000000;
		opcode_out = 8'h00;
		addr_out = 24'h000000;
	end
	always @(negedge cs_b_in) begin
		bit_cnt = 0;
		frames_out = frames_out + 1;
	end
	// Released line must not keep showing the last bit
	always @(posedge cs_b_in)
		miso_out = ~miso_out;
	always @(posedge sck_in) begin
		if (!cs_b_in) begin
			if (bit_cnt < 32)
				cmd = {cmd[30:0], mosi_in};
			bit_cnt = bit_cnt + 1;
			if (bit_cnt == 32) begin
				opcode_out = cmd[31:24];
				addr_out = cmd[23:0];
			end
		end
	end
	// Data changes after each falling edge, first bit right after the dummy byte
	always @(negedge sck_in) begin
		if (!cs_b_in && bit_cnt >= 40) begin
			idx = bit_cnt - 40;
			cur = rom_byte(cmd[23:0] + 24'(idx / 8), sig_ok_in);
			miso_out = cur[7 - idx % 8];
		end else if (!cs_b_in) begin
			miso_out = ~miso_out;
		end
	end
endmodule // flash_rom_model

// file: test/spi_rom_fetch_and_straps_tb_top.sv
// Self-checking bench for the flash fetch sequencer and strap latch.
// Assumes the flash model on the serial pins; undriven straps read the board level.
`timescale 1ns/1ps
module spi_rom_fetch_and_straps_tb_top
	import spi_rom_fetch_pkg::*;
;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic ce_in = 1'b1;
	logic spi_disable_in = 1'b0;
	logic suspend_in = 1'b0;
	logic cpu_rd_in = 1'b0;
	logic [16:0] cpu_addr_in = 17'h00000;
	logic cpu_stall_in = 1'b0;
	logic [STRAP_COUNT-1:0] strap_func_in = 9'h0A5;
	logic [STRAP_COUNT-1:0] strap_val = 9'h000;
	logic sig_ok = 1'b1;
	logic cpu_ready_out, ext_rom_en_out, boot_done_out, fast_flash_clk_out;
	logic flash_cs_b_out, flash_sck_out, flash_mosi_out, flash_miso_in;
	logic [7:0] cpu_data_out;
	logic [7:0] opcode;
	logic [23:0] addr;
	logic [STRAP_COUNT-1:0] strap_pin_in, strap_pin_out, strap_pin_oe_out;
	logic [PORT_COUNT-1:0] port_neg_line_off_out, port_pos_line_off_out, port_disable_out;
	int frames;
	int f0;
	int fail_count = 0;
	int check_count = 0;
	logic got;
	logic [7:0] d;
	logic sck_hold;

	always #20 clk_in = ~clk_in;
	// Pin level: our drive when enabled, otherwise the strap resistor
	assign strap_pin_in = (strap_pin_oe_out & strap_pin_out) | (~strap_pin_oe_out & strap_val);

	spi_rom_fetch_and_straps i_spi_rom_fetch_and_straps (.clk_in, .rst_b_in, .ce_in,
		.spi_disable_in, .suspend_in, .cpu_rd_in, .cpu_addr_in, .cpu_stall_in, .cpu_ready_out,
		.cpu_data_out, .ext_rom_en_out, .boot_done_out, .flash_cs_b_out, .flash_sck_out,
		.flash_mosi_out, .flash_miso_in, .strap_pin_in, .strap_func_in, .strap_pin_out,
		.strap_pin_oe_out, .port_neg_line_off_out, .port_pos_line_off_out, .port_disable_out,
		.fast_flash_clk_out);
	flash_rom_model i_flash_rom_model (.cs_b_in(flash_cs_b_out), .sck_in(flash_sck_out),
		.mosi_in(flash_mosi_out), .miso_out(flash_miso_in), .sig_ok_in(sig_ok),
		.opcode_out(opcode), .addr_out(addr), .frames_out(frames));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic do_reset(input logic [8:0] straps, input logic ok);
		@(negedge clk_in);
		rst_b_in = 1'b0;
		strap_val = straps;
		sig_ok = ok;
		repeat (20) @(negedge clk_in);
		check(strap_pin_oe_out, 9'h000, "strap drive in reset");
		check(flash_cs_b_out, 1'b1, "select in reset");
		rst_b_in = 1'b1;
		for (int i = 0; i < 600 && boot_done_out !== 1'b1; i++)
			@(negedge clk_in);
		check(boot_done_out, 1'b1, "boot finished");
	endtask

	task automatic check_straps(input logic [3:0] neg, input logic [3:0] pos, input logic fast);
		check(port_neg_line_off_out, neg, "neg straps");
		check(port_pos_line_off_out, pos, "pos straps");
		check(port_disable_out, neg & pos, "port off");
		check(fast_flash_clk_out, fast, "speed strap");
		check(strap_pin_oe_out, 9'h1FF, "strap drive");
		check(strap_pin_out, strap_func_in, "strap value");
		suspend_in = 1'b1;
		repeat (3) @(negedge clk_in);
		check(strap_pin_oe_out[STRAP_SPEED_BIT], !fast, "speed pin drive in suspend");
		check(strap_pin_out[STRAP_SPEED_BIT], 1'b0, "speed pin level in suspend");
		suspend_in = 1'b0;
	endtask

	task automatic fetch(input logic [16:0] a, output logic ok, output logic [7:0] v);
		@(negedge clk_in);
		cpu_rd_in = 1'b1;
		cpu_addr_in = a;
		@(negedge clk_in);
		cpu_rd_in = 1'b0;
		ok = 1'b0;
		v = 8'h00;
		for (int i = 0; i < 400 && !ok; i++) begin
			if (cpu_ready_out === 1'b1) begin
				ok = 1'b1;
				v = cpu_data_out;
			end else begin
				@(negedge clk_in);
			end
		end
	endtask

	task automatic rd_check(input logic [16:0] a);
		fetch(a, got, d);
		check(got, 1'b1, "byte ready");
		check(d, a[7:0] ^ a[15:8] ^ 8'h5A, "byte value");
	endtask

	// Serial clock must rest low whenever the flash is deselected
	always @(negedge clk_in)
		if (rst_b_in && flash_cs_b_out === 1'b1)
			check(flash_sck_out, 1'b0, "clock idle");

	initial begin
		do_reset(9'h053, 1'b1);
		check_straps(4'h3, 4'h5, 1'b0);
		check(ext_rom_en_out, 1'b1, "external code on");
		$display("test straps_slow finished");
		f0 = frames;
		rd_check(17'h00000);
		check(opcode, FAST_READ_OPCODE, "opcode");
		check(addr, 24'h000000, "frame address");
		rd_check(17'h00001);
		rd_check(17'h00002);
		check(frames, f0 + 1, "one frame for a run");
		rd_check(17'h1FFFF);
		check(addr, 24'h01FFFF, "new frame address");
		check(frames, f0 + 2, "jump opens a frame");
		rd_check(17'h01234);
		cpu_stall_in = 1'b1;
		fork
			begin
				repeat (150) @(negedge clk_in);
				cpu_stall_in = 1'b0;
			end
		join_none
		rd_check(17'h01235);
		check(cpu_stall_in, 1'b0, "ready held while stalled");
		check(frames, f0 + 3, "stall keeps frame");
		$display("test fetch finished");
		spi_disable_in = 1'b1;
		fetch(17'h01236, got, d);
		check(got, 1'b0, "no answer when off");
		check(flash_cs_b_out, 1'b1, "deselected when off");
		spi_disable_in = 1'b0;
		// Freeze the block mid-frame; two cycles always hold one serial clock edge
		fork
			begin
				repeat (60) @(negedge clk_in);
				ce_in = 1'b0;
				sck_hold = flash_sck_out;
				repeat (2) @(negedge clk_in);
				check(flash_sck_out, sck_hold, "clock frozen");
				repeat (10) @(negedge clk_in);
				check(flash_cs_b_out, 1'b0, "frame kept while frozen");
				ce_in = 1'b1;
			end
		join_none
		rd_check(17'h00040);
		$display("test disable finished");
		do_reset(9'h1AC, 1'b1);
		check_straps(4'hC, 4'hA, 1'b1);
		rd_check(17'h00010);
		$display("test straps_fast finished");
		do_reset(9'h000, 1'b0);
		check(ext_rom_en_out, 1'b0, "internal code kept");
		fetch(17'h00000, got, d);
		check(got, 1'b0, "flash unused");
		check(flash_cs_b_out, 1'b1, "select idle");
		$display("test no_signature finished");
		spi_disable_in = 1'b1;
		f0 = frames;
		do_reset(9'h000, 1'b1);
		check(ext_rom_en_out, 1'b0, "external code off when disabled");
		check(frames, f0, "no frame when disabled");
		spi_disable_in = 1'b0;
		$display("test boot_disabled finished");
		wrap_up();
	end

	initial begin
		repeat (30000) @(posedge clk_in);
		fail_count++;
		wrap_up();
	end
endmodule // spi_rom_fetch_and_straps_tb_top
